// [design/fcs_pkg.sv]
// package: constants and types for the flash command sequencer
package fcs_pkg;
    // command codes
    localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
    localparam logic [7:0] CMD_VERIFY_BLK = 8'h02;
    localparam logic [7:0] CMD_PROGRAM = 8'h06;
    localparam logic [7:0] CMD_READ_ONCE = 8'h07;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
    // parameter indices
    localparam logic [2:0] IDX_0 = 3'h0;
    localparam logic [2:0] IDX_1 = 3'h1;
    localparam logic [2:0] IDX_PROG_LAST = 3'h5;
    // block selection codes
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_PROG = 2'h3;
    // margin level and phrase index limits
    localparam logic [15:0] MARGIN_MAX = 16'h0004;
    localparam logic [15:0] PHRASE_MAX = 16'h0007;
    // reset values
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [2:0] MARGIN_RESET = 3'h0;
    localparam logic [2:0] SCEN_RESET = 3'h7;
    // cycles an algorithm stays busy
    localparam int ALGO_NS = 1000;
    localparam int CLK_NS = 50;
    localparam logic [7:0] ALGO_CYCLES = 8'(ALGO_NS / CLK_NS);

    typedef struct packed {
        logic verify_error_bit;
        logic verify_uncorrectable_bit;
    } fcs_verify_s;

    typedef struct packed {
        logic command_complete_flag;
        logic access_error_flag;
        logic protect_violation_flag;
        fcs_verify_s verify_status_bits;
    } fcs_status_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } fcs_state_e;
endpackage

// [design/fcs_sequencer.sv]
// flash command sequencer: parameter array, launch, checks, protection
// =====================================================================
`timescale 1ns/1ns
module fcs_sequencer
    import fcs_pkg::*;
(
    input wire logic clk, // 20 MHz bus clock
    input wire logic rst, // synchronous reset, active high
    input wire logic special_mode, // chip is in a special mode
    input wire logic divider_loaded, // clock divider register initialized
    input wire logic [7:0] nv_data_protect, // nonvolatile protect image
    input wire logic index_wr, // write the parameter index
    input wire logic [2:0] index_wdata, // new index
    input wire logic param_wr, // write the indexed parameter word
    input wire logic [15:0] param_wdata, // parameter word
    input wire logic launch, // starts a command; clears the complete flag unless the command is refused
    input wire logic clear_errors, // clear access and protect errors
    input wire logic prot_wr, // write the program protect scenario
    input wire logic [2:0] prot_wdata, // requested scenario
    input wire logic dprot_wr, // write the data protect register
    input wire logic [7:0] dprot_wdata, // open bit and size
    input wire logic clear_faults, // clear single and double fault flags
    input wire logic rd_req, // array read strobe
    input wire logic rd_is_prog, // read targets the program block
    input wire logic array_blank, // array returns blank for the check
    input wire logic array_rd_err, // correctable read error seen
    input wire logic array_rd_fatal, // non-correctable read error seen
    input wire logic [63:0] once_phrase, // phrase from the once field
    input wire logic prog_ok, // program read-back matched
    output logic [2:0] param_index, // current parameter index
    output logic [15:0] param_rdata, // indexed parameter word
    output fcs_status_s flash_status_reg, // status bits
    output logic [2:0] program_block_protect_reg, // active scenario
    output logic [7:0] data_block_protect_reg, // open bit and size
    output logic data_protect_active, // data protection in force
    output logic single_fault_flag, // single fault flag
    output logic double_fault_flag, // double fault flag
    output logic rd_invalid, // current read returns invalid data
    output logic [2:0] data_margin, // level for data-block reads
    output logic [2:0] prog_margin // level for program-block reads
);

    // =================================================================
    // parameter array
    logic [15:0] command_param_array [0:5];
    logic [2:0] index_q;
    fcs_state_e state_q;
    logic [7:0] cmd_q;
    logic [7:0] count_q;
    logic fetch_once;

    always_ff @(posedge clk) begin
        if (rst) begin
            index_q <= IDX_0;
        end else if (index_wr && state_q == ST_IDLE) begin
            index_q <= index_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_word
            // words 0 and 1 never take phrase data; keep their slice legal
            localparam int PH = (gi >= 2) ? gi - 2 : 0;
            always_ff @(posedge clk) begin
                if (rst) begin
                    command_param_array[gi] <= 16'h0000;
                end else if (fetch_once && gi >= 2) begin
                    command_param_array[gi] <=
                        once_phrase[PH*16 +: 16];
                end else if (param_wr && state_q == ST_IDLE &&
                             index_q == 3'(gi)) begin
                    command_param_array[gi] <= param_wdata;
                end
            end
        end
    endgenerate

    logic [15:0] sel_word;
    always_comb begin
        sel_word = 16'h0000;
        if (index_q <= IDX_PROG_LAST) begin
            sel_word = command_param_array[index_q];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            param_index <= IDX_0;
            param_rdata <= 16'h0000;
        end else begin
            param_index <= index_q;
            param_rdata <= sel_word;
        end
    end

    // =================================================================
    // launch checks
    logic [7:0] code;
    logic [1:0] blk;
    logic bad;
    assign code = command_param_array[0][15:8];
    assign blk = command_param_array[0][1:0];
    assign fetch_once = state_q == ST_RUN && cmd_q == CMD_READ_ONCE &&
                        count_q == 8'h01;

    always_comb begin
        bad = 1'b0;
        case (code)
            CMD_VERIFY_ALL: bad = index_q != IDX_0;
            CMD_VERIFY_BLK: bad = index_q != IDX_0 ||
                (blk != SEL_DATA && blk != SEL_PROG);
            CMD_FIELD_MARGIN: bad = index_q != IDX_1 || !special_mode ||
                command_param_array[1] > MARGIN_MAX ||
                (blk != SEL_DATA && blk != SEL_PROG);
            CMD_READ_ONCE: bad = index_q != IDX_1 || special_mode ||
                command_param_array[1] > PHRASE_MAX;
            CMD_PROGRAM: bad = index_q != IDX_PROG_LAST ||
                command_param_array[1][2:0] != 3'h0 ||
                !divider_loaded;
            default: bad = 1'b1;
        endcase
        if ((code == CMD_VERIFY_ALL || code == CMD_VERIFY_BLK) &&
            !divider_loaded) begin
            bad = 1'b1;
        end
    end

    // =================================================================
    // command state machine
    logic go;
    assign go = launch && state_q == ST_IDLE &&
                !flash_status_reg.access_error_flag &&
                !flash_status_reg.protect_violation_flag;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= 8'h00;
            count_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go && !bad) begin
                        state_q <= ST_RUN;
                        cmd_q <= code;
                        count_q <= ALGO_CYCLES;
                    end
                end
                ST_RUN: begin
                    count_q <= count_q - 8'h01;
                    if (count_q == 8'h01) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // =================================================================
    // status
    logic blank_fail_q;
    always_ff @(posedge clk) begin
        if (rst || (go && !bad)) begin
            blank_fail_q <= 1'b0;
        end else if (state_q == ST_RUN && !array_blank &&
                     (cmd_q == CMD_VERIFY_ALL ||
                      cmd_q == CMD_VERIFY_BLK)) begin
            blank_fail_q <= 1'b1;
        end
    end

    logic err_q, fatal_q;
    always_ff @(posedge clk) begin
        if (rst || (go && !bad)) begin
            err_q <= 1'b0;
            fatal_q <= 1'b0;
        end else if (state_q == ST_RUN) begin
            if (array_rd_err || array_rd_fatal ||
                (cmd_q == CMD_PROGRAM && !prog_ok)) begin
                err_q <= 1'b1;
            end
            if (array_rd_fatal) begin
                fatal_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flash_status_reg <= '{1'b1, 1'b0, 1'b0, 2'b00};
        end else begin
            if (go) begin
                flash_status_reg.command_complete_flag <= bad;
                flash_status_reg.verify_status_bits <= 2'b00;
            end else if (state_q == ST_DONE) begin
                flash_status_reg.command_complete_flag <= 1'b1;
                flash_status_reg.verify_status_bits <=
                    {err_q | blank_fail_q,
                     fatal_q | blank_fail_q};
            end
            // a new error wins over a clear in the same cycle
            if (go && bad) begin
                flash_status_reg.access_error_flag <= 1'b1;
            end else if (clear_errors) begin
                flash_status_reg.access_error_flag <= 1'b0;
                flash_status_reg.protect_violation_flag <= 1'b0;
            end
        end
    end

    // =================================================================
    // margin levels
    logic [2:0] dm_q, pm_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            dm_q <= MARGIN_RESET;
            pm_q <= MARGIN_RESET;
        end else if (state_q == ST_DONE && cmd_q == CMD_FIELD_MARGIN) begin
            if (command_param_array[0][1:0] == SEL_PROG) begin
                pm_q <= command_param_array[1][2:0];
                dm_q <= command_param_array[1][2:0];
            end else begin
                dm_q <= command_param_array[1][2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_margin <= MARGIN_RESET;
            prog_margin <= MARGIN_RESET;
        end else begin
            data_margin <= dm_q;
            prog_margin <= pm_q;
        end
    end

    // =================================================================
    // read-while-busy
    logic busy_hit;
    always_comb begin
        busy_hit = 1'b0;
        if (state_q != ST_IDLE && rd_req) begin
            case (cmd_q)
                CMD_VERIFY_ALL: busy_hit = 1'b1;
                CMD_VERIFY_BLK: busy_hit =
                    rd_is_prog == (command_param_array[0][1:0] == SEL_PROG);
                CMD_PROGRAM, CMD_READ_ONCE: busy_hit = rd_is_prog;
                default: busy_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            single_fault_flag <= 1'b0;
            double_fault_flag <= 1'b0;
            rd_invalid <= 1'b0;
        end else begin
            rd_invalid <= busy_hit;
            if (busy_hit) begin
                single_fault_flag <= 1'b1;
                double_fault_flag <= 1'b1;
            end else if (clear_faults) begin
                single_fault_flag <= 1'b0;
                double_fault_flag <= 1'b0;
            end
        end
    end

    // =================================================================
    // protection registers
    logic [7:0] allowed;
    always_comb begin
        case (program_block_protect_reg)
            3'h0: allowed = 8'h0f;
            3'h1: allowed = 8'h0a;
            3'h2: allowed = 8'h0c;
            3'h3: allowed = 8'h08;
            3'h4: allowed = 8'h18;
            3'h5: allowed = 8'h3c;
            3'h6: allowed = 8'h5a;
            3'h7: allowed = 8'hff;
            default: allowed = 8'h00;
        endcase
    end

    // reload strobe: first cycle after reset release
    logic load_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            program_block_protect_reg <= SCEN_RESET;
        end else if (prot_wr && allowed[prot_wdata]) begin
            program_block_protect_reg <= prot_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_block_protect_reg <= PROT_RESET;
        end else if (load_q) begin
            data_block_protect_reg <= nv_data_protect;
        end else if (dprot_wr) begin
            if (!dprot_wdata[7]) begin
                data_block_protect_reg[7] <= 1'b0;
            end
            if (dprot_wdata[6:0] > data_block_protect_reg[6:0]) begin
                data_block_protect_reg[6:0] <= dprot_wdata[6:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_protect_active <= 1'b0;
        end else begin
            data_protect_active <= !data_block_protect_reg[7];
        end
    end

endmodule

// [test/fcs_seq_props.sv]
// checker: port-level properties of the flash command sequencer
`timescale 1ns/1ns
module fcs_seq_props
    import fcs_pkg::*;
(
    input wire logic clk, // bus clock
    input wire logic rst, // sync reset
    input wire logic launch, // command start
    input wire logic prot_wr, // scenario write
    input wire logic dprot_wr, // data protect write
    input wire logic rd_req, // array read
    input wire fcs_status_s flash_status_reg, // status
    input wire logic [2:0] program_block_protect_reg, // scenario
    input wire logic [7:0] data_block_protect_reg, // data protect
    input wire logic data_protect_active, // protection on
    input wire logic single_fault_flag, // single fault
    input wire logic double_fault_flag, // double fault
    input wire logic rd_invalid, // invalid read
    input wire logic [2:0] data_margin, // data level
    input wire logic [2:0] prog_margin // program level
);
    // ====================================================
    // helpers
    // allowed scenario steps, one byte per source scenario
    localparam logic [63:0] PROT_OK =
        {8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f};
    logic [1:0] age_q;
    logic cc;
    logic [2:0] pbp;
    logic [6:0] data_protect_size;
    assign cc = flash_status_reg.command_complete_flag;
    assign pbp = program_block_protect_reg;
    assign data_protect_size = data_block_protect_reg[6:0];
    // the nonvolatile reload lands just after reset, so skip those edges
    always_ff @(posedge clk) begin
        if (rst) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // ====================================================
    // properties
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    AST_RUN_LEN: assert property (
        $fell(cc) |-> $past(launch) ##21 cc)
        else $error("command run length wrong");
    AST_ERR_NO_RUN: assert property (
        $rose(flash_status_reg.access_error_flag) |-> cc && $past(launch))
        else $error("refused command started a run");
    AST_NO_VIOL: assert property (
        !$rose(flash_status_reg.protect_violation_flag))
        else $error("protect violation raised");
    AST_VERIFY_CLR: assert property (
        $fell(cc) |-> ##[0:1] flash_status_reg.verify_status_bits == 2'b00)
        else $error("verify bits not cleared at launch");
    AST_PROT_STEP: assert property (
        $changed(pbp) |-> $past(prot_wr) && PROT_OK[{$past(pbp), pbp}])
        else $error("illegal scenario transition");
    AST_DPS_UP: assert property (
        age_q == 2'h3 && $changed(data_protect_size) |->
        $past(dprot_wr) && data_protect_size > $past(data_protect_size))
        else $error("data protect size shrank");
    AST_OPEN_ONEWAY: assert property (
        age_q == 2'h3 && $changed(data_block_protect_reg[7]) |->
        !data_block_protect_reg[7])
        else $error("open bit reopened");
    AST_OPEN_IDLE: assert property (
        data_block_protect_reg[7] && $past(data_block_protect_reg[7]) |->
        !data_protect_active)
        else $error("protection active while open");
    AST_BAD_READ: assert property (
        rd_invalid |-> $past(rd_req) && !$past(cc))
        else $error("invalid read outside a run");
    AST_FAULTS: assert property (
        $rose(rd_invalid) |->
        ##[0:1] (single_fault_flag && double_fault_flag))
        else $error("fault flags not set");
    AST_PROG_BOTH: assert property (
        $changed(prog_margin) |-> ##[0:1] data_margin == prog_margin)
        else $error("program level not on both blocks");
    cover property ($fell(cc));
    cover property ($rose(flash_status_reg.access_error_flag));
    cover property ($rose(rd_invalid));
endmodule
bind fcs_sequencer fcs_seq_props u_props (.clk, .rst, .launch, .prot_wr,
    .dprot_wr, .rd_req, .flash_status_reg, .program_block_protect_reg,
    .data_block_protect_reg, .data_protect_active, .single_fault_flag,
    .double_fault_flag, .rd_invalid, .data_margin, .prog_margin);

// [test/testbench.sv]
// testbench: directed scenarios for the flash command sequencer
`timescale 1ns/1ns
module testbench;
    import fcs_pkg::*;
    logic clk, rst, special_mode, divider_loaded, index_wr, param_wr, launch;
    logic clear_errors, prot_wr, dprot_wr, clear_faults, rd_req, rd_is_prog;
    logic array_blank, array_rd_err, array_rd_fatal, prog_ok;
    logic [2:0] index_wdata, prot_wdata, param_index, pbp;
    logic [2:0] data_margin, prog_margin;
    logic [15:0] param_wdata, param_rdata;
    logic [7:0] nv_data_protect, dprot_wdata, dbp;
    logic [63:0] once_phrase;
    logic dpa, sff, dff, rd_invalid;
    fcs_status_s st;
    int errors, checks;
    fcs_sequencer DUT (.clk, .rst, .special_mode, .divider_loaded,
        .nv_data_protect, .index_wr, .index_wdata, .param_wr, .param_wdata,
        .launch, .clear_errors, .prot_wr, .prot_wdata, .dprot_wr,
        .dprot_wdata, .clear_faults, .rd_req, .rd_is_prog, .array_blank,
        .array_rd_err, .array_rd_fatal, .once_phrase, .prog_ok, .param_index,
        .param_rdata, .flash_status_reg(st), .program_block_protect_reg(pbp),
        .data_block_protect_reg(dbp), .data_protect_active(dpa),
        .single_fault_flag(sff), .double_fault_flag(dff), .rd_invalid,
        .data_margin, .prog_margin);
    // ====================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic set_idx(input logic [2:0] i);
        index_wr = 1'b1;
        index_wdata = i;
        @(negedge clk);
        index_wr = 1'b0;
    endtask
    task automatic wr_word(input logic [2:0] i, input logic [15:0] d);
        set_idx(i);
        param_wr = 1'b1;
        param_wdata = d;
        @(negedge clk);
        param_wr = 1'b0;
    endtask
    // a refused command must leave complete standing, then errors are cleared
    task automatic go(input logic err);
        launch = 1'b1;
        @(negedge clk);
        launch = 1'b0;
        chk(16'(st.access_error_flag), 16'(err));
        chk(16'(st.command_complete_flag), 16'(err));
        for (int n = 0; n < 40 && st.command_complete_flag !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk(16'(st.command_complete_flag), 16'h1);
        clear_errors = 1'b1;
        @(negedge clk);
        clear_errors = 1'b0;
    endtask
    task automatic run(input logic [15:0] w0, input logic [15:0] w1,
                       input logic [2:0] last, input logic err);
        wr_word(IDX_0, w0);
        wr_word(IDX_1, w1);
        set_idx(last);
        go(err);
    endtask
    // ====================================================
    // scenarios
    task automatic t_verify();
        for (int k = 0; k < 4; k++) begin
            array_blank = k[0];
            run({CMD_VERIFY_BLK, 6'h0, k[1] ? SEL_PROG : SEL_DATA}, 16'h0,
                IDX_0, 1'b0);
            chk(16'(st.verify_status_bits), k[0] ? 16'h0 : 16'h3);
        end
        array_blank = 1'b1;
        array_rd_err = 1'b1;
        run({CMD_VERIFY_ALL, 8'h0}, 16'h0, IDX_0, 1'b0);
        chk(16'(st.verify_status_bits), 16'h2);
        array_rd_fatal = 1'b1;
        run({CMD_VERIFY_ALL, 8'h0}, 16'h0, IDX_0, 1'b0);
        chk(16'(st.verify_status_bits), 16'h3);
        {array_rd_err, array_rd_fatal, array_blank} = 3'h0;
        run({CMD_VERIFY_ALL, 8'h0}, 16'h0, IDX_0, 1'b0);
        chk(16'(st.verify_status_bits), 16'h3);
        array_blank = 1'b1;
    endtask
    task automatic t_errors();
        run({CMD_VERIFY_BLK, 8'h01}, 16'h0, IDX_0, 1'b1);
        run({CMD_VERIFY_BLK, 8'h00}, 16'h0, IDX_1, 1'b1);
        run({CMD_VERIFY_ALL, 8'h00}, 16'h0, IDX_1, 1'b1);
        run({8'h33, 8'h00}, 16'h0, IDX_0, 1'b1);
        divider_loaded = 1'b0;
        run({CMD_PROGRAM, 8'h00}, 16'h0, IDX_PROG_LAST, 1'b1);
        divider_loaded = 1'b1;
        wr_word(IDX_0, {8'h33, 8'h00});
        launch = 1'b1;
        @(negedge clk);
        launch = 1'b0;
        wr_word(IDX_0, {CMD_VERIFY_ALL, 8'h00});
        go(1'b1);
    endtask
    task automatic t_margin();
        special_mode = 1'b1;
        for (int l = 0; l < 5; l++) begin
            run({CMD_FIELD_MARGIN, 6'h0, SEL_DATA}, 16'(l), IDX_1,
                1'b0);
            chk({13'h0, data_margin}, 16'(l));
            chk({13'h0, prog_margin}, 16'h0);
        end
        run({CMD_FIELD_MARGIN, 6'h0, SEL_PROG}, 16'h3, IDX_1, 1'b0);
        chk({5'h0, data_margin, 5'h0, prog_margin}, 16'h0303);
        run({CMD_FIELD_MARGIN, 6'h0, SEL_PROG}, 16'h5, IDX_1, 1'b1);
        special_mode = 1'b0;
        run({CMD_FIELD_MARGIN, 6'h0, SEL_DATA}, 16'h0, IDX_1, 1'b1);
    endtask
    task automatic t_once();
        once_phrase = 64'h4444_3333_2222_1111;
        wr_word(IDX_0, {CMD_READ_ONCE, 8'h00});
        wr_word(IDX_1, 16'h0007);
        launch = 1'b1;
        rd_is_prog = 1'b1;
        @(negedge clk);
        launch = 1'b0;
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        chk(16'(rd_invalid), 16'h1);
        @(negedge clk);
        chk({14'h0, sff, dff}, 16'h3);
        for (int n = 0; n < 40 && st.command_complete_flag !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk(16'(st), 16'h10);
        clear_faults = 1'b1;
        for (int i = 2; i < 6; i++) begin
            set_idx(3'(i));
            clear_faults = 1'b0;
            @(negedge clk);
            chk({13'h0, param_index}, 16'(i));
            chk(param_rdata, 16'(i - 1) * 16'h1111);
        end
        chk({14'h0, sff, dff}, 16'h0);
        run({CMD_READ_ONCE, 8'h00}, 16'h0008, IDX_1, 1'b1);
        run({CMD_READ_ONCE, 8'h00}, 16'h0000, IDX_0, 1'b1);
        special_mode = 1'b1;
        run({CMD_READ_ONCE, 8'h00}, 16'h0000, IDX_1, 1'b1);
        special_mode = 1'b0;
    endtask
    task automatic t_program();
        wr_word(IDX_0, {CMD_PROGRAM, 8'h00});
        wr_word(IDX_1, 16'h0010);
        for (int i = 2; i < 6; i++) begin
            wr_word(3'(i), 16'h1234);
        end
        go(1'b0);
        chk(16'(st), 16'h10);
    endtask
    task automatic t_protect();
        logic [2:0] req [6] = '{3'h6, 3'h5, 3'h1, 3'h2, 3'h3, 3'h0};
        logic [2:0] exp [6] = '{3'h6, 3'h6, 3'h1, 3'h1, 3'h3, 3'h3};
        logic [7:0] dreq [4] = '{8'h87, 8'h84, 8'h08, 8'h88};
        logic [15:0] dexp [4] = '{16'h0087, 16'h0087, 16'h0108, 16'h0108};
        for (int k = 0; k < 6; k++) begin
            prot_wdata = req[k];
            prot_wr = 1'b1;
            @(negedge clk);
            prot_wr = 1'b0;
            @(negedge clk);
            chk({13'h0, pbp}, {13'h0, exp[k]});
        end
        for (int k = 0; k < 4; k++) begin
            dprot_wdata = dreq[k];
            dprot_wr = 1'b1;
            @(negedge clk);
            dprot_wr = 1'b0;
            @(negedge clk);
            chk({7'h0, dpa, dbp}, dexp[k]);
        end
    endtask
    // ====================================================
    // clock, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        errors = 0;
        checks = 0;
        rst = 1'b1;
        {divider_loaded, array_blank, prog_ok} = 3'h7;
        {index_wr, param_wr, launch, clear_errors, prot_wr, dprot_wr} = '0;
        {clear_faults, rd_req, rd_is_prog, special_mode} = '0;
        {array_rd_err, array_rd_fatal} = '0;
        {index_wdata, prot_wdata, param_wdata, dprot_wdata} = '0;
        nv_data_protect = 8'h85;
        once_phrase = 64'h0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk({8'h0, dbp}, 16'h0085);
        chk({13'h0, pbp}, 16'h7);
        chk({11'h0, st}, 16'h10);
        t_verify();
        t_errors();
        t_margin();
        t_once();
        t_program();
        t_protect();
        end_of_test();
    end
    // some twenty-seven commands of up to about thirty cycles each fit well inside this
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule
